/* File: rtl/afc_feature_control_two.sv */
// Feature control two: status byte, queue token, interrupt clear, stream, trigger
`timescale 1ns/10ps
`default_nettype none
`include "afc_map.svh"
module afc_feature_control_two #(
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] feature_control_two,
  input wire afc_pkg::afc_if_mode_t if_mode,
  input wire logic i2c_enable,
  input wire logic spi_frame_start,
  input wire logic spi_first_byte,
  input wire logic [7:0] status_flags,
  output logic serial_out_addr_pin_en,
  output logic [7:0] serial_out_status,
  input wire logic interrupt_pending_flag,
  output logic clear_interrupts,
  input wire logic queue_enable,
  input wire logic [3:0] resolution_bits,
  input wire logic sample_valid,
  input wire logic [15:0] sample_z,
  input wire logic queue_pop,
  input wire logic [7:0] queue_threshold,
  output logic [15:0] queue_z_data,
  output logic queue_full,
  output logic queue_empty,
  output logic queue_threshold_flag,
  input wire logic interrupt_trigger_pin,
  input wire logic [2:0] mode_control,
  input wire logic oneshot_command,
  input wire logic [7:0] trigger_sample_count,
  output logic external_sample_req,
  output logic trigger_sleep_req
);
  localparam int AW = $clog2(DEPTH);
  // Fill count must fit the 8-bit threshold compare; queue needs a power of 2
  if (DEPTH < 2 || DEPTH > 128) begin : g_depth_bad
    $error("DEPTH out of range");
  end
  logic [7:0] fct_r;
  logic [7:0] fct_nxt;
  logic clear_r;
  logic [7:0] status_r;
  logic status_en_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_d_r;
  logic sample_req_r;
  logic sleep_r;
  logic [7:0] done_cnt_r;
  logic [AW:0] fill_r;
  logic [15:0] z_out_r;
  afc_pkg::afc_trg_state_t trg_r;
  afc_pkg::afc_trg_state_t trg_nxt;

  // Register access
  wire sel_fct = (reg_addr == `AFC_REG_FEATURE_CONTROL_TWO);
  wire sel_int = (reg_addr == `AFC_REG_INT_STATUS);
  assign fct_nxt = (reg_wr && sel_fct) ? reg_wdata : fct_r;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fct_r <= `AFC_FCT_RESET;
    end else begin
      fct_r <= fct_nxt;
    end
  end
  assign feature_control_two = fct_r;
  wire spi_stat_en = fct_r[`AFC_BIT_SPI_STAT];
  wire token_en = fct_r[`AFC_BIT_QUEUE_TOKEN];
  wire wr_clear = fct_r[`AFC_BIT_WR_CLEAR];
  wire stream_en = fct_r[`AFC_BIT_STREAM];
  wire edge_rise = fct_r[`AFC_BIT_TRIGGERED_SAMPLING_MODE_EDGE];
  wire pin_triggered_sampling_mode = fct_r[`AFC_BIT_PIN_TRIGGERED_SAMPLING_MODE];

  // Interrupt clearing
  wire is_i2c = (if_mode == afc_pkg::AFC_IF_I2C);
  wire is_spi = (if_mode == afc_pkg::AFC_IF_SPI4) ||
    (if_mode == afc_pkg::AFC_IF_SPI3);
  wire i2c_wclr = wr_clear && i2c_enable;
  wire clr_by_read = is_i2c && reg_rd && sel_int && !i2c_wclr;
  wire clr_by_write = reg_wr && sel_int && (is_spi || (is_i2c && i2c_wclr));
  wire clear_nxt = clr_by_read || clr_by_write;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clear_r <= 1'b0;
    end else begin
      clear_r <= clear_nxt;
    end
  end
  assign clear_interrupts = clear_r;

  // SPI status byte on the first byte of 4-wire transfers
  wire status_go = spi_frame_start && spi_stat_en &&
    (if_mode == afc_pkg::AFC_IF_SPI4);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= 8'h00;
      status_en_r <= 1'b0;
    end else begin
      if (status_go) begin
        status_r <= status_flags;
      end
      status_en_r <= status_go || (status_en_r && spi_first_byte);
    end
  end
  assign serial_out_status = status_r;
  assign serial_out_addr_pin_en = status_en_r;

  // Sample queue and Z-channel status token
  afc_queue_if #(.DW(16)) qif ();
  assign qif.push = sample_valid;
  assign qif.push_data = sample_z;
  assign qif.pop = queue_pop;
  assign qif.stream = stream_en && queue_enable;
  assign qif.enable = queue_enable;
  afc_sample_queue #(.DW(16), .DEPTH(DEPTH)) u_queue (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .q(qif)
  );
  wire pop_ok = queue_pop && !qif.empty;
  // A push into a full queue is taken when a pop frees a slot the same cycle
  wire push_net = sample_valid && queue_enable && (!qif.full || pop_ok);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fill_r <= '0;
    end else begin
      fill_r <= fill_r + (AW+1)'(push_net) - (AW+1)'(pop_ok);
    end
  end
  wire thr_hit = (8'(fill_r) >= queue_threshold);
  wire [3:0] token = {interrupt_pending_flag, thr_hit, qif.full, qif.empty};
  wire low_res = (resolution_bits < 4'(`AFC_TOKEN_RES_BITS));
  wire [15:0] z_tok_hi = {token, qif.pop_data[11:0]};
  wire [15:0] z_tok_lo = {qif.pop_data[15:4], token};
  wire [15:0] z_tok = low_res ? z_tok_hi : z_tok_lo;
  wire [15:0] z_sel = token_en ? z_tok : qif.pop_data;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      z_out_r <= 16'h0000;
    end else begin
      z_out_r <= z_sel;
    end
  end
  assign queue_z_data = z_out_r;
  assign queue_full = qif.full;
  assign queue_empty = qif.empty;
  assign queue_threshold_flag = thr_hit;

  // External trigger on the interrupt pin
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Reset to the pin's idle high so no false edge follows reset
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_d_r <= 1'b1;
    end else begin
      pin_s1_r <= interrupt_trigger_pin;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end
  wire rise = pin_s2_r && !pin_d_r;
  wire fall = !pin_s2_r && pin_d_r;
  wire pin_edge = edge_rise ? rise : fall;
  wire triggered_sampling_mode_mode = (mode_control == `AFC_MODE_TRIGGERED) && !oneshot_command;
  wire triggered_sampling_mode_ok = pin_triggered_sampling_mode && triggered_sampling_mode_mode;
  wire count_on = (trigger_sample_count != 8'h00);
  wire last = count_on && (done_cnt_r + 8'h01 >= trigger_sample_count);
  always_comb begin
    trg_nxt = trg_r;
    case (trg_r)
      afc_pkg::AFC_TRG_IDLE: begin
        if (triggered_sampling_mode_ok) begin
          trg_nxt = afc_pkg::AFC_TRG_RUN;
        end
      end
      afc_pkg::AFC_TRG_RUN: begin
        if (!triggered_sampling_mode_ok) begin
          trg_nxt = afc_pkg::AFC_TRG_IDLE;
        end else if (pin_edge && last) begin
          trg_nxt = afc_pkg::AFC_TRG_DONE;
        end
      end
      afc_pkg::AFC_TRG_DONE: begin
        if (!triggered_sampling_mode_ok) begin
          trg_nxt = afc_pkg::AFC_TRG_IDLE;
        end
      end
      default: trg_nxt = afc_pkg::AFC_TRG_IDLE;
    endcase
  end
  wire take = (trg_r == afc_pkg::AFC_TRG_RUN) && triggered_sampling_mode_ok && pin_edge;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trg_r <= afc_pkg::AFC_TRG_IDLE;
      done_cnt_r <= 8'h00;
      sample_req_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      trg_r <= trg_nxt;
      sample_req_r <= take;
      sleep_r <= take && last;
      if (trg_r != afc_pkg::AFC_TRG_RUN) begin
        done_cnt_r <= 8'h00;
      end else if (take && done_cnt_r != `AFC_TRIGGERED_SAMPLING_MODE_MAX_SAMPLES) begin
        done_cnt_r <= done_cnt_r + 8'h01;
      end
    end
  end
  assign external_sample_req = sample_req_r;
  assign trigger_sleep_req = sleep_r;
endmodule // afc_feature_control_two
`default_nettype wire

/* File: rtl/afc_map.svh */
// Offsets, field positions, reset values, mode codes and sample limits of feature control two
`ifndef AFC_MAP_SVH
`define AFC_MAP_SVH
`define AFC_REG_FEATURE_CONTROL_TWO 8'h0E
`define AFC_REG_INT_STATUS 8'h09
`define AFC_FCT_RESET 8'h00
`define AFC_BIT_SPI_STAT 2
`define AFC_BIT_QUEUE_TOKEN 3
`define AFC_BIT_WR_CLEAR 4
`define AFC_BIT_STREAM 5
`define AFC_BIT_TRIGGERED_SAMPLING_MODE_EDGE 6
`define AFC_BIT_PIN_TRIGGERED_SAMPLING_MODE 7
`define AFC_MODE_TRIGGERED 3'h7
`define AFC_MODE_SLEEP 3'h0
`define AFC_TOKEN_RES_BITS 14
`define AFC_TRIGGERED_SAMPLING_MODE_MAX_SAMPLES 8'hFE
`endif

/* File: rtl/afc_pkg.sv */
// Types shared by the feature control two block
`default_nettype none
package afc_pkg;
  typedef enum logic [1:0] {
    AFC_IF_NONE,
    AFC_IF_I2C,
    AFC_IF_SPI4,
    AFC_IF_SPI3
  } afc_if_mode_t;
  typedef enum logic [1:0] {
    AFC_TRG_IDLE,
    AFC_TRG_RUN,
    AFC_TRG_DONE
  } afc_trg_state_t;
endpackage
`default_nettype wire

/* File: rtl/afc_queue_if.sv */
// Interface between the top and its sample queue
`timescale 1ns/10ps
`default_nettype none
interface afc_queue_if #(parameter int DW = 16);
  logic push;
  logic [DW-1:0] push_data;
  logic pop;
  logic [DW-1:0] pop_data;
  logic full;
  logic empty;
  logic stream;
  logic enable;
  modport owner (output push, push_data, pop, stream, enable,
    input pop_data, full, empty);
  modport queue (input push, push_data, pop, stream, enable,
    output pop_data, full, empty);
endinterface
`default_nettype wire

/* File: rtl/afc_sample_queue.sv */
// Sample queue with stop-when-full or stream (discard oldest) behaviour
`timescale 1ns/10ps
`default_nettype none
module afc_sample_queue #(
  parameter int DW = 16,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  afc_queue_if.queue q
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_bad
    $error("DEPTH must be a power of two of at least 2");
  end
  logic [DW-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  wire is_full = (cnt_r == (AW+1)'(DEPTH));
  wire is_empty = (cnt_r == '0);
  wire do_pop = q.pop && !is_empty;
  // Stream drops the oldest entry when full; otherwise a full queue refuses a push unless a pop frees a slot
  wire drop_old = q.stream && is_full && !do_pop;
  wire do_push = q.push && q.enable && (!is_full || do_pop || drop_old);
  wire adv_rd = do_pop || (do_push && drop_old);
  wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(do_push && !drop_old)
    - (AW+1)'(do_pop);
  assign q.full = is_full;
  assign q.empty = is_empty;
  assign q.pop_data = mem_r[rd_r];
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem_r[wr_r] <= q.push_data;
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_r + AW'(do_push);
      rd_r <= rd_r + AW'(adv_rd);
      cnt_r <= cnt_nxt;
    end
  end
endmodule // afc_sample_queue
`default_nettype wire

/* File: tb/afc_feature_control_two_props.sv */
// Checker for feature control two
`timescale 1ns/10ps
`default_nettype none
module afc_fct_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] feature_control_two,
  input wire afc_pkg::afc_if_mode_t if_mode,
  input wire logic i2c_enable,
  input wire logic spi_frame_start,
  input wire logic spi_first_byte,
  input wire logic [7:0] status_flags,
  input wire logic serial_out_addr_pin_en,
  input wire logic [7:0] serial_out_status,
  input wire logic clear_interrupts
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire i2c = if_mode == afc_pkg::AFC_IF_I2C;
  wire spi4 = if_mode == afc_pkg::AFC_IF_SPI4;
  wire spi = spi4 || if_mode == afc_pkg::AFC_IF_SPI3;
  wire hit = reg_addr == 8'h09;
  wire wrc = feature_control_two[4] && i2c_enable;
  wire fw = reg_wr && reg_addr == 8'h0E;
  sequence clr_wr_s; reg_wr && hit; endsequence
  sequence clr_rd_s; reg_rd && !reg_wr && hit; endsequence
  fct_write_a: assert property (
    fw |=> feature_control_two == $past(reg_wdata))
    else $error("control byte not written");
  fct_hold_a: assert property (
    !fw |=> $stable(feature_control_two))
    else $error("control byte changed");
  spi_wr_a: assert property (
    clr_wr_s ##0 spi |=> clear_interrupts)
    else $error("spi write did not clear");
  spi_rd_a: assert property (
    clr_rd_s ##0 spi |=> !clear_interrupts)
    else $error("spi read cleared");
  i2c_rd_a: assert property (
    clr_rd_s ##0 (i2c && !wrc) |=> clear_interrupts)
    else $error("i2c read did not clear");
  wr_clear_a: assert property (
    clr_wr_s ##0 (i2c && wrc) |=> clear_interrupts)
    else $error("i2c write did not clear");
  rd_keep_a: assert property (
    clr_rd_s ##0 (i2c && wrc) |=> !clear_interrupts)
    else $error("i2c read cleared");
  stat_on_a: assert property (
    spi_frame_start && spi_first_byte && spi4 && feature_control_two[2]
    |=> serial_out_addr_pin_en && serial_out_status == $past(status_flags))
    else $error("status byte missing");
  stat_off_a: assert property (
    spi_frame_start && !(spi4 && feature_control_two[2])
    |=> !serial_out_addr_pin_en)
    else $error("status byte driven");
  stat_end_a: assert property (
    serial_out_addr_pin_en && !spi_first_byte |=> !serial_out_addr_pin_en)
    else $error("status byte overran");
endmodule // afc_fct_props
bind afc_feature_control_two afc_fct_props afc_fct_props_i (.*);
`default_nettype wire

/* File: tb/afc_feature_control_two_test.sv */
// Self-checking bench for feature control two
`timescale 1ns/10ps
`default_nettype none
module afc_feature_control_two_test;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, i2c_enable = 1'b0, run = 1'b0;
  logic spi_frame_start = 1'b0, spi_first_byte = 1'b0;
  logic interrupt_pending_flag = 1'b1, queue_enable = 1'b1;
  logic sample_valid = 1'b0, queue_pop = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] status_flags = 8'hA5, queue_threshold = 8'h01;
  logic [7:0] trigger_sample_count = 8'h03;
  logic [3:0] resolution_bits = 4'hC;
  logic [15:0] sample_z = 16'h0000;
  afc_pkg::afc_if_mode_t if_mode = afc_pkg::AFC_IF_I2C;
  logic [7:0] feature_control_two, serial_out_status;
  logic [15:0] queue_z_data;
  logic [2:0] mode_control;
  logic serial_out_addr_pin_en, clear_interrupts, queue_full, queue_empty;
  logic queue_threshold_flag, interrupt_trigger_pin, oneshot_command;
  logic external_sample_req, trigger_sleep_req;
  int fails = 0, checks = 0, nreq = 0, nslp = 0;
  afc_feature_control_two #(.DEPTH(4)) afc_feature_control_two_i (.*);
  afc_host_model afc_host_model_i (.core_clk(core_clk), .run(run),
    .trigger_sleep_req(trigger_sleep_req), .triggered_sampling_mode_pin(interrupt_trigger_pin),
    .mode_control(mode_control), .oneshot_command(oneshot_command));
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (external_sample_req === 1'b1) nreq++;
    if (trigger_sleep_req === 1'b1) nslp++;
  end
  task wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task acc(input logic w, input logic [7:0] a, d);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  task q(input logic p, input logic [15:0] d);
    @(posedge core_clk);
    sample_valid <= !p;
    queue_pop <= p;
    sample_z <= d;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    queue_pop <= 1'b0;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset", feature_control_two, 16'h0000);
    acc(1'b1, 8'h0E, 8'hFC);
    acc(1'b1, 8'h0D, 8'h00);
    chk("hold", feature_control_two, 16'h00FC);
    // Interface mode, enable and select against read and write of 0x09
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      if_mode <= afc_pkg::afc_if_mode_t'(i < 4 ? 1 : i - 2);
      i2c_enable <= i[0];
      acc(1'b1, 8'h0E, {3'h0, i[1], 4'h0});
      acc(1'b0, 8'h09, 8'h00);
      chk("rd clr", clear_interrupts, i < 4 && !(i[1] && i[0]));
      acc(1'b1, 8'h09, 8'h5A);
      chk("wr clr", clear_interrupts, i > 3 || (i[1] && i[0]));
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      if_mode <= afc_pkg::afc_if_mode_t'(i == 1 ? 3 : i == 2 ? 1 : 2);
      acc(1'b1, 8'h0E, i == 3 ? 8'h00 : 8'h04);
      @(posedge core_clk);
      spi_frame_start <= 1'b1;
      spi_first_byte <= 1'b1;
      @(posedge core_clk);
      spi_frame_start <= 1'b0;
      #1;
      chk("stat en", serial_out_addr_pin_en, i == 0);
      if (i == 0) chk("stat", serial_out_status, 16'h00A5);
      @(posedge core_clk);
      spi_first_byte <= 1'b0;
      step(2);
      chk("stat end", serial_out_addr_pin_en, 1'b0);
    end
    @(posedge core_clk);
    if_mode <= afc_pkg::AFC_IF_I2C;
    acc(1'b1, 8'h0E, 8'h08);
    q(1'b0, 16'hABCD);
    step(3);
    chk("tok hi", queue_z_data, 16'hCBCD);
    chk("thr", queue_threshold_flag, 1'b1);
    @(posedge core_clk);
    resolution_bits <= 4'hE;
    step(3);
    chk("tok lo", queue_z_data, 16'hABCC);
    acc(1'b1, 8'h0E, 8'h00);
    step(2);
    chk("tok off", queue_z_data, 16'hABCD);
    q(1'b1, 16'h0000);
    // Overfill by one, then drain
    for (int s = 0; s < 2; s++) begin
      acc(1'b1, 8'h0E, s ? 8'h20 : 8'h00);
      for (int k = 0; k < 5; k++) q(1'b0, 16'h0010 + k);
      step(2);
      chk("full", queue_full, 1'b1);
      chk("head", queue_z_data, 16'h0010 + s);
      repeat (4) q(1'b1, 16'h0000);
      step(2);
      chk("drain", queue_empty, 1'b1);
      chk("thr low", queue_threshold_flag, 1'b0);
    end
    // Stream set but queue disabled: nothing is stored
    @(posedge core_clk);
    queue_enable <= 1'b0;
    q(1'b0, 16'h0020);
    step(2);
    chk("q off", queue_empty, 1'b1);
    @(posedge core_clk);
    queue_enable <= 1'b1;
    acc(1'b1, 8'h0E, 8'h40);
    @(posedge core_clk);
    run <= 1'b1;
    step(64);
    chk("no triggered_sampling_mode", 16'(nreq), 16'h0000);
    @(posedge core_clk);
    run <= 1'b0;
    acc(1'b1, 8'h0E, 8'hC0);
    nreq = 0;
    @(posedge core_clk);
    run <= 1'b1;
    step(160);
    chk("triggered_sampling_mode", 16'(nreq), 16'h0003);
    chk("sleep", 16'(nslp), 16'h0001);
    // Continuous count on falling edges: many samples, no sleep
    @(posedge core_clk);
    run <= 1'b0;
    trigger_sample_count <= 8'h00;
    acc(1'b1, 8'h0E, 8'h80);
    step(4);
    nreq = 0;
    @(posedge core_clk);
    run <= 1'b1;
    step(160);
    chk("cont", 16'(nreq > 3), 16'h0001);
    chk("no sleep", 16'(nslp), 16'h0001);
    wrap_up;
  end
endmodule // afc_feature_control_two_test
`default_nettype wire

/* File: tb/afc_host_model.sv */
// Host side model: trigger pin and mode selection
`timescale 1ns/10ps
`default_nettype none
module afc_host_model (
  input wire logic core_clk,
  input wire logic run,
  input wire logic trigger_sleep_req,
  output logic triggered_sampling_mode_pin,
  output logic [2:0] mode_control,
  output logic oneshot_command
);
  logic asleep = 1'b0;
  // Pin starts high and holds its level between bursts, toggles every 40 ns while run is set
  initial begin
    triggered_sampling_mode_pin = 1'b1;
    forever begin
      #40;
      if (run) triggered_sampling_mode_pin = ~triggered_sampling_mode_pin;
    end
  end
  assign oneshot_command = 1'b0;
  assign mode_control = asleep ? 3'h0 : 3'h7;
  always @(posedge core_clk) begin
    asleep <= trigger_sleep_req ? 1'b1 : asleep && run;
  end
endmodule // afc_host_model
`default_nettype wire
